// >>> hw/hbpwm_pkg.sv
package hbpwm_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 8;
  localparam int CNT_W = 9;
  localparam int EXT_W = 6;
  localparam int DUTY_W = 10;
  localparam int PRE_W = 4;
  localparam int LINES_PER_PORT = 8;
  localparam int CH_PER_PORT = 4;
  localparam int SIGN_BIT = 9;
  localparam logic [CNT_W-1:0] CNT_MAX = 9'h1ff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [EXT_W-1:0] EXT_MAX = 6'h3f;
  localparam logic [EXT_W-1:0] EXT_ZERO = 6'h00;
  localparam logic [DUTY_W-2:0] DUTY_ZERO = 9'h000;
  localparam logic [DUTY_W-1:0] DUTY_RST = 10'h3ff;
  localparam logic [NCH-1:0] BYTE_ZERO = 8'h00;
  // ----------------------------------------------------------------
  // clock c prescale codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PRE_2E = 2'h0;
  localparam logic [1:0] PRE_E = 2'h1;
  localparam logic [1:0] PRE_E2 = 2'h2;
  localparam logic [1:0] PRE_E4 = 2'h3;
  // ----------------------------------------------------------------
  // timing: clk is 40 MHz, e clock is 10 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int T_E_PS = 100000;
  localparam int QUARTER_E_CYC = (T_E_PS / 4 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int E_CYC = T_E_PS / CLK_PERIOD_PS;
  // clk cycles per clock c tick, minus one
  localparam logic [PRE_W-1:0] DIV_2E = PRE_W'(E_CYC / 2 - 1);
  localparam logic [PRE_W-1:0] DIV_E = PRE_W'(E_CYC - 1);
  localparam logic [PRE_W-1:0] DIV_E2 = PRE_W'(E_CYC * 2 - 1);
  localparam logic [PRE_W-1:0] DIV_E4 = PRE_W'(E_CYC * 4 - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = 4'h0;
endpackage

// >>> hw/hbpwm_chan.sv
`timescale 1ns/1ps
`default_nettype none
module hbpwm_chan
  import hbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input wire logic [CNT_W-1:0] count,
  input wire logic [DUTY_W-1:0] duty_in,
  input wire logic start_level,
  input wire logic enable,
  output logic pwm_level,
  output logic reversed,
  output logic sample_strobe
);
  typedef struct packed {
    logic [DUTY_W-1:0] duty;
    logic lvl;
    logic strobe;
  } hbpwm_chan_t;

  hbpwm_chan_t st_r;
  hbpwm_chan_t st_nxt;
  logic pol;
  logic start;

  always_comb begin
    st_nxt = st_r;
    start = step && (count == CNT_ZERO);
    // the sign bit inverts the waveform as well as swapping the lines
    pol = start_level ^ st_r.duty[SIGN_BIT];
    st_nxt.strobe = start; // RL13
    if (!enable) begin
      // a disabled channel takes new duty values at once
      st_nxt.duty = duty_in;
    end else if (start) begin
      st_nxt.duty = duty_in;
    end
    if (st_nxt.duty[DUTY_W-2:0] == DUTY_ZERO) begin
      st_nxt.lvl = ~(start_level ^ st_nxt.duty[SIGN_BIT]); // RL1 RL2
    end else if (start) begin
      st_nxt.lvl = start_level ^ st_nxt.duty[SIGN_BIT];
    end else if (step && count == st_r.duty[DUTY_W-2:0]) begin
      st_nxt.lvl = ~pol;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{duty: DUTY_RST, lvl: 1'b0, strobe: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwm_level = st_r.lvl;
  assign reversed = st_r.duty[SIGN_BIT];
  assign sample_strobe = st_r.strobe;
endmodule
`default_nettype wire

// >>> hw/hbpwm_ext.sv
`timescale 1ns/1ps
`default_nettype none
module hbpwm_ext
  import hbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic c_tick,
  input wire logic wrap,
  input wire logic bypass,
  input wire logic clear,
  output logic [EXT_W-1:0] ext_count,
  output logic overflow
);
  typedef struct packed {
    logic [EXT_W-1:0] cnt;
    logic ovf;
  } hbpwm_ext_t;

  hbpwm_ext_t st_r;
  hbpwm_ext_t st_nxt;
  logic adv;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf = 1'b0;
    // in bypass the extension counts clock c directly
    adv = bypass ? c_tick : wrap; // RL4 RL7
    if (clear) begin
      st_nxt.cnt = EXT_ZERO; // RL6 RL8
    end else if (adv) begin
      st_nxt.cnt = st_r.cnt + 6'h01;
      st_nxt.ovf = (st_r.cnt == EXT_MAX); // RL5
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{cnt: EXT_ZERO, ovf: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ext_count = st_r.cnt;
  assign overflow = st_r.ovf;
endmodule
`default_nettype wire

// >>> hw/hbpwm_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (RL1) zero duty, start level 0: output high
// (RL2) zero duty, start level 1: output low
// (RL3) channel k period start delayed k quarter-e
// (RL4) six extension bits: interrupt every 64 periods
// (RL5) extension overflow raises period interrupt
// (RL6) counter write clears counter and extension
// (RL7) bypass clocks extension directly from clock c
// (RL8) bypass: counter write still clears both
// (RL9) wait halts the pwm clock
// (RL10) stop halts all; registers hold values; here clears still act and pins follow port data
// (RL11) enabled lines carry pwm, else port data
// (RL12) sensed versus intended level compared by xor
// (RL13) result sampled quarter-e after shifted start
// (RL14) mismatch bit sticky until written one
// (RL15) software polls mismatch at least every 10ms
// (RL16) one line static high, other carries pwm
// (RL17) sign bit swaps pwm and static lines
// (RL18) software writes port data ones first
// (RL19) small-angle use: never change sign bit
// (RL20) period flag set by hardware, write-one clear
// (RL21) interrupt forwarded only while mask is 1
// (RL22) prescale codes select 2e, e, e/2, e/4
// (RL23) nine-bit counter counts to 1ff, wraps
// (RL24) each mismatch bit clears alone; zero ignored
module hbpwm_top
  import hbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NCH-1:0][DUTY_W-1:0] channel_duty_value,
  input wire logic [NCH-1:0] channel_start_level,
  input wire logic [NCH-1:0] channel_output_enable,
  input wire logic [1:0] clock_c_prescale_select,
  input wire logic period_interrupt_mask,
  input wire logic period_flag_clear,
  input wire logic counter_write,
  input wire logic interrupt_counter_bypass,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic [LINES_PER_PORT-1:0] port_h_output_data,
  input wire logic [LINES_PER_PORT-1:0] port_k_output_data,
  input wire logic [LINES_PER_PORT-1:0] sensed_pin_level_h,
  input wire logic [LINES_PER_PORT-1:0] sensed_pin_level_k,
  input wire logic [LINES_PER_PORT-1:0] port_h_short_clear,
  input wire logic [LINES_PER_PORT-1:0] port_k_short_clear,
  output logic [LINES_PER_PORT-1:0] port_h_pin,
  output logic [LINES_PER_PORT-1:0] port_k_pin,
  output logic [CNT_W-1:0] shared_period_counter,
  output logic period_interrupt_flag,
  output logic period_irq,
  output logic [LINES_PER_PORT-1:0] port_h_short_flags,
  output logic [LINES_PER_PORT-1:0] port_k_short_flags
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
    logic [NCH-1:0][CNT_W-1:0] cnt_dl;
    logic [NCH-1:0] step_dl;
    logic flag;
    logic irq;
    logic [LINES_PER_PORT-1:0] pin_h;
    logic [LINES_PER_PORT-1:0] pin_k;
    logic [LINES_PER_PORT-1:0] short_h;
    logic [LINES_PER_PORT-1:0] short_k;
  } hbpwm_top_t;

  hbpwm_top_t st_r;
  hbpwm_top_t st_nxt;

  logic [PRE_W-1:0] div_last;
  logic run;
  logic c_tick;
  logic wrap;
  logic ext_ovf;
  logic [EXT_W-1:0] ext_count;
  logic [NCH-1:0] ch_lvl;
  logic [NCH-1:0] ch_rev;
  logic [NCH-1:0] ch_strobe;
  logic [LINES_PER_PORT-1:0] mis_h;
  logic [LINES_PER_PORT-1:0] mis_k;

  // ----------------------------------------------------------------
  // clock c prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (clock_c_prescale_select) // RL22
      PRE_2E: div_last = DIV_2E;
      PRE_E: div_last = DIV_E;
      PRE_E2: div_last = DIV_E2;
      PRE_E4: div_last = DIV_E4;
      default: div_last = DIV_E;
    endcase
  end

  // wait stops the pwm clock, stop stops everything; nothing below
  // advances while run is low, so the counters hold; pins still follow port data and clears still act
  assign run = !cpu_wait && !cpu_stop; // RL9 RL10
  assign c_tick = run && (st_r.pre >= div_last);
  assign wrap = c_tick && !counter_write && (st_r.cnt == CNT_MAX);

  // ----------------------------------------------------------------
  // interrupt extension counter
  // ----------------------------------------------------------------
  hbpwm_ext u_ext (
    .clk(clk),
    .rst(rst),
    .c_tick(c_tick),
    .wrap(wrap),
    .bypass(interrupt_counter_bypass),
    .clear(counter_write),
    .ext_count(ext_count),
    .overflow(ext_ovf)
  );

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    hbpwm_chan u_chan (
      .clk(clk),
      .rst(rst),
      .step(st_r.step_dl[k]),
      .count(st_r.cnt_dl[k]),
      .duty_in(channel_duty_value[k]),
      .start_level(channel_start_level[k]),
      .enable(channel_output_enable[k]),
      .pwm_level(ch_lvl[k]),
      .reversed(ch_rev[k]),
      .sample_strobe(ch_strobe[k])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    int li;
    int ri;
    int pc;
    logic [LINES_PER_PORT-1:0] data;
    logic [LINES_PER_PORT-1:0] pins;
    logic [LINES_PER_PORT-1:0] sensed;
    logic [LINES_PER_PORT-1:0] mis;
    li = 0;
    ri = 0;
    pc = 0;
    data = BYTE_ZERO;
    pins = BYTE_ZERO;
    sensed = BYTE_ZERO;
    mis = BYTE_ZERO;
    st_nxt = st_r;
    mis_h = BYTE_ZERO;
    mis_k = BYTE_ZERO;

    // prescaler and shared counter
    if (!run) begin
      st_nxt.pre = st_r.pre;
    end else if (c_tick || counter_write) begin
      st_nxt.pre = PRE_ZERO;
    end else begin
      st_nxt.pre = st_r.pre + 4'h1;
    end
    if (counter_write) begin
      st_nxt.cnt = CNT_ZERO; // RL6 RL8
    end else if (c_tick) begin
      st_nxt.cnt = st_r.cnt + 9'h001; // RL23
    end

    // each stage of the delay line is one quarter e clock, so
    // channel k sees the counter k quarters later than channel 0
    if (run) begin
      st_nxt.cnt_dl[0] = st_r.cnt;
      st_nxt.step_dl[0] = c_tick && !counter_write;
      for (int k = 1; k < NCH; k++) begin
        st_nxt.cnt_dl[k] = st_r.cnt_dl[k-1]; // RL3
        st_nxt.step_dl[k] = st_r.step_dl[k-1]; // RL3
      end
    end
    if (counter_write) begin
      // a truncated period must not leak stale steps to late channels
      st_nxt.step_dl = BYTE_ZERO;
    end

    // period interrupt flag: a new overflow beats a clear
    if (ext_ovf) begin
      st_nxt.flag = 1'b1; // RL5 RL20
    end else if (period_flag_clear) begin
      st_nxt.flag = 1'b0; // RL20
    end
    st_nxt.irq = st_nxt.flag && period_interrupt_mask; // RL21

    // line drive and mismatch per port
    for (int p = 0; p < 2; p++) begin
      data = (p == 0) ? port_h_output_data : port_k_output_data;
      pins = data; // RL11
      sensed = (p == 0) ? sensed_pin_level_h : sensed_pin_level_k;
      mis = BYTE_ZERO;
      for (int c = 0; c < CH_PER_PORT; c++) begin
        pc = p * CH_PER_PORT + c;
        li = 2 * c;
        ri = 2 * c + 1;
        if (channel_output_enable[pc]) begin
          // static side follows its data bit, held high by software
          if (ch_rev[pc]) begin
            pins[ri] = ch_lvl[pc]; // RL16 RL17
          end else begin
            pins[li] = ch_lvl[pc]; // RL16 RL17
          end
        end
        if (ch_strobe[pc] && run) begin // RL10
          // the pins sampled are those driven before the start level reaches them; no sampling
          // while halted, so no flag is set during wait and stop
          mis[li] = sensed[li] ^ ((p == 0) ? st_r.pin_h[li] : st_r.pin_k[li]); // RL12 RL13
          mis[ri] = sensed[ri] ^ ((p == 0) ? st_r.pin_h[ri] : st_r.pin_k[ri]); // RL12 RL13
        end
      end
      if (p == 0) begin
        st_nxt.pin_h = pins;
        mis_h = mis;
      end else begin
        st_nxt.pin_k = pins;
        mis_k = mis;
      end
    end

    // sticky short flags; a fresh mismatch beats the clear
    st_nxt.short_h = (st_r.short_h & ~port_h_short_clear) | mis_h; // RL14 RL24
    st_nxt.short_k = (st_r.short_k & ~port_k_short_clear) | mis_k; // RL14 RL24
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign port_h_pin = st_r.pin_h;
  assign port_k_pin = st_r.pin_k;
  assign shared_period_counter = st_r.cnt;
  assign period_interrupt_flag = st_r.flag;
  assign period_irq = st_r.irq;
  assign port_h_short_flags = st_r.short_h;
  assign port_k_short_flags = st_r.short_k;
endmodule
`default_nettype wire

// >>> dv/hbpwm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checker
// ----------------
module hbpwm_checker
  import hbpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NCH-1:0] channel_output_enable,
  input wire logic period_interrupt_mask,
  input wire logic period_flag_clear,
  input wire logic counter_write,
  input wire logic interrupt_counter_bypass,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic [LINES_PER_PORT-1:0] port_h_output_data,
  input wire logic [LINES_PER_PORT-1:0] port_h_short_clear,
  input wire logic [LINES_PER_PORT-1:0] port_h_pin,
  input wire logic [CNT_W-1:0] shared_period_counter,
  input wire logic period_interrupt_flag,
  input wire logic period_irq,
  input wire logic [LINES_PER_PORT-1:0] port_h_short_flags
);
  // history from inside reset is not trusted on the first edge after it
  logic live_r;
  wire logic halt = cpu_wait | cpu_stop;
  wire logic [CNT_W-1:0] cnt = shared_period_counter;
  always_ff @(posedge clk) live_r <= !rst;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // irq is registered from the flag's next value, so it rises with the flag
  sequence s_masked;
    live_r && period_interrupt_flag && $past(period_interrupt_mask);
  endsequence
  sequence s_halted;
    live_r && $past(halt);
  endsequence
  a_irq_masked: assert property (s_masked |-> period_irq)
    else $error("irq missing");
  a_irq_gated: assert property (live_r && !(period_interrupt_flag &&
    $past(period_interrupt_mask)) |-> !period_irq) else $error("irq not gated");
  a_write_clears: assert property (live_r && counter_write && !halt |=> cnt == CNT_ZERO)
    else $error("counter not cleared");
  a_count_step: assert property (live_r && $changed(cnt) |->
    cnt == CNT_ZERO || cnt == $past(cnt) + 9'h001) else $error("counter jump");
  a_halt_holds: assert property (s_halted |-> $stable(cnt) && $stable(port_h_pin) &&
    $stable(period_interrupt_flag) && $stable(port_h_short_flags)) else $error("state moved");
  a_flag_clear: assert property (live_r && $fell(period_interrupt_flag) |->
    $past(period_flag_clear)) else $error("flag lost");
  a_flag_cause: assert property (live_r && $rose(period_interrupt_flag) &&
    !$past(interrupt_counter_bypass, 2) |-> $past(cnt) == CNT_ZERO) else $error("flag early");
  a_short_sticky: assert property (live_r |-> ($past(port_h_short_flags) &
    ~port_h_short_flags & ~$past(port_h_short_clear)) == BYTE_ZERO) else $error("flag dropped");
  a_data_line: assert property (live_r && !$past(channel_output_enable[0]) && !$past(halt) |->
    port_h_pin[1:0] == $past(port_h_output_data[1:0])) else $error("data line wrong");
endmodule
bind hbpwm_top hbpwm_checker chk (.clk, .rst, .channel_output_enable, .period_interrupt_mask,
  .period_flag_clear, .counter_write, .interrupt_counter_bypass, .cpu_wait, .cpu_stop,
  .port_h_output_data, .port_h_short_clear, .port_h_pin, .shared_period_counter,
  .period_interrupt_flag, .period_irq, .port_h_short_flags);
`default_nettype wire

// >>> dv/hbpwm_drivers.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// bridge drivers
// ----------------
module hbpwm_drivers (
  input wire logic [7:0] pin,
  input wire logic [7:0] short,
  output logic [7:0] sense
);
  // a shorted driver drags its line to the opposite level
  assign sense = pin ^ short;
endmodule
`default_nettype wire

// >>> dv/hbridge_pwm_timing_and_fault_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// bench
// ----------------
module hbridge_pwm_timing_and_fault_monitor_test
  import hbpwm_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [NCH-1:0][DUTY_W-1:0] duty = '0;
  logic [7:0] start = 8'h00, en = 8'h00, dh = 8'hff, dk = 8'hff, ch = 8'h00, sh = 8'h00;
  logic [1:0] pre = 2'h0;
  logic mask = 1'h0, fclr = 1'h0, cwr = 1'h0, byp = 1'h0, wt = 1'h0, stp = 1'h0;
  logic [7:0] sk = 8'h00;
  logic [7:0] sen_h, sen_k, ph, pk, fh, fk;
  logic [CNT_W-1:0] cnt, v;
  logic flag, irq;
  int checks = 0, fail_count = 0, i, w;
  hbpwm_top dut (.clk(clk), .rst(rst), .channel_duty_value(duty), .channel_start_level(start),
    .channel_output_enable(en), .clock_c_prescale_select(pre), .period_interrupt_mask(mask),
    .period_flag_clear(fclr), .counter_write(cwr), .interrupt_counter_bypass(byp),
    .cpu_wait(wt), .cpu_stop(stp), .port_h_output_data(dh), .port_k_output_data(dk),
    .sensed_pin_level_h(sen_h), .sensed_pin_level_k(sen_k), .port_h_short_clear(ch),
    .port_k_short_clear(ch), .port_h_pin(ph), .port_k_pin(pk), .shared_period_counter(cnt),
    .period_interrupt_flag(flag), .period_irq(irq), .port_h_short_flags(fh),
    .port_k_short_flags(fk));
  hbpwm_drivers drv (.pin(ph), .short(sh), .sense(sen_h));
  hbpwm_drivers drv_k (.pin(pk), .short(sk), .sense(sen_k));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bound(input int n);
    if (i >= n) begin
      check("wait", 9'h000, 9'h001);
      conclude();
    end
  endtask
  task automatic t_data();
    dh = 8'h5a;
    dk = 8'hc3;
    step(2);
    check("pin h", ph, 9'h05a);
    check("pin k", pk, 9'h0c3);
    dh = 8'hff;
    dk = 8'hff; // static sides held high before any channel runs
    step(2);
  endtask
  task automatic t_rate();
    for (int c = 0; c < 4; c++) begin
      pre = c[1:0];
      cwr = 1'h1;
      step(1);
      cwr = 1'h0;
      step(8);
      v = cnt;
      step(32);
      check("rate", cnt - v, 9'(16 >> c));
    end
  endtask
  task automatic t_halt();
    pre = PRE_2E;
    v = cnt;
    wt = 1'h1;
    step(20);
    check("wait", cnt, v);
    wt = 1'h0;
    stp = 1'h1;
    step(20);
    check("stop", cnt, v);
    stp = 1'h0;
  endtask
  task automatic t_zero();
    logic [1:0] want [4] = '{2'h3, 2'h2, 2'h1, 2'h3};
    en = 8'h01;
    for (int k = 0; k < 4; k++) begin
      duty[0] = {k[1], 9'h000};
      start[0] = k[0];
      step(1100);
      repeat (1030) begin
        step(1);
        check("zero duty", ph[1:0], want[k]);
      end
    end
  endtask
  task automatic t_shift();
    en = 8'h03;
    duty[0] = 10'h003;
    duty[1] = 10'h003;
    start[1:0] = 2'h3;
    step(1100);
    for (i = 0; i < 1100 && !(ph[0] && !ph[2]); i++) step(1);
    bound(1100);
    step(1);
    check("shift", ph[2], 9'h001);
  endtask
  task automatic t_short();
    sh = 8'h01;
    sk = 8'h02;
    step(1100);
    check("short set", fh, 9'h001);
    check("short k set", fk, 9'h002);
    sh = 8'h00;
    sk = 8'h00;
    ch = 8'hfe;
    step(1);
    ch = 8'h01;
    check("short kept", fh, 9'h001);
    check("short k clear", fk, 9'h000);
    step(1);
    ch = 8'h00;
    step(1);
    check("short clear", fh, 9'h000);
  endtask
  task automatic t_irq();
    mask = 1'h1;
    byp = 1'h1;
    for (i = 0; i < 400 && !flag; i++) step(1);
    bound(400);
    fclr = 1'h1;
    step(1);
    fclr = 1'h0;
    check("flag clear", flag, 9'h000);
    for (i = 1; i < 400 && !flag; i++) step(1);
    bound(400);
    check("bypass gap", i[8:0], 9'h080);
    step(1);
    check("irq", irq, 9'h001);
    fclr = 1'h1;
    step(1);
    fclr = 1'h0;
    step(62);
    cwr = 1'h1;
    step(1);
    cwr = 1'h0;
    step(70);
    check("bypass write", flag, 9'h000);
    byp = 1'h0;
    mask = 1'h0;
    cwr = 1'h1;
    step(1);
    cwr = 1'h0;
    w = 0;
    v = cnt;
    // wraps are counted, not cycles, so prescaler phase cannot skew it
    for (i = 0; i < 70000 && !flag; i++) begin
      step(1);
      if (cnt < v) w++;
      v = cnt;
    end
    bound(70000);
    check("periods", w[8:0], 9'h040);
    step(1);
    check("irq masked", irq, 9'h000);
  endtask
  initial begin
    step(4);
    rst = 1'h0;
    t_data();
    t_rate();
    t_halt();
    t_zero();
    t_shift();
    t_short();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
